// *** gpp_port_set.sv ***
// general-purpose ports of a 4-bit controller: latches, direction words, pin muxing
// assumes pins are synchronised here, register port is on MCLK_IN, and the
// pad ring resolves open-drain pins from the enables
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "gpp_defs.svh"
module gpp_port_set
    import gpp_pkg::*;
(
    // clock and reset
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic CE_PIN_IN,
    // register port
    input wire logic REG_RF_SEL_IN,
    input wire logic [`GPP_BANK_W-1:0] REG_BANK_IN,
    input wire logic [`GPP_ADDR_W-1:0] REG_ADDR_IN,
    input wire logic [3:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [3:0] REG_RDATA_OUT,
    output logic CE_RESET_OUT,
    // serial interface side
    input wire logic SIO_EN_IN,
    input wire logic SIO_TWOWIRE_IN,
    input wire logic SIO_SO_IN,
    input wire logic SIO_SCK_IN,
    input wire logic SIO_SCK_OE_IN,
    input wire logic SIO_SCL_LOW_IN,
    input wire logic SIO_SDA_LOW_IN,
    output logic SIO_SI_OUT,
    output logic SIO_SCK_OUT,
    output logic SIO_SCL_OUT,
    output logic SIO_SDA_OUT,
    output logic HSYNC_CNT_OUT,
    // clock stop from the oscillator control
    input wire logic CLK_STOP_IN,
    // pins
    input wire logic [3:0] PORT_A0_IN,
    input wire logic [3:0] PORT_B0_IN,
    input wire logic [3:0] PORT_C1_IN,
    input wire logic [3:0] PORT_D0_IN,
    output logic [3:0] PORT_A1_OE_OUT,
    output logic [3:0] PORT_A1_OUT,
    output logic [3:0] PORT_A0_OUT,
    output logic [3:0] PORT_A0_OE_OUT,
    output logic [3:0] PORT_B0_OUT,
    output logic [3:0] PORT_B0_OE_OUT,
    output logic [3:0] PORT_B2_OE_OUT,
    output logic [3:0] PORT_C0_OUT,
    output logic [3:0] PORT_C1_OUT,
    output logic [3:0] PORT_C1_OE_OUT,
    output logic [3:0] PORT_C2_OE_OUT
);
    gpp_state_t s_q, s_d;
    gpp_req_t req;
    gpp_sio_t sio;
    logic [3:0] a0_s1_q, a0_s2_q, b0_s1_q, b0_s2_q, c1_s1_q, c1_s2_q, d0_s1_q, d0_s2_q;
    logic ce_s1_q, ce_s2_q, stop_s1_q, stop_s2_q;
    logic ce_rise, port_reset;
    logic [3:0] a0_pin, b0_pin;

    // gather the request and serial hookup into carriers
    assign req = '{REG_RF_SEL_IN, REG_BANK_IN, REG_ADDR_IN, REG_WDATA_IN, REG_WR_IN, REG_RD_IN};
    assign sio = '{SIO_EN_IN, SIO_TWOWIRE_IN, SIO_SO_IN, SIO_SCK_IN, SIO_SCK_OE_IN,
                   SIO_SCL_LOW_IN, SIO_SDA_LOW_IN};

    // two-flop synchronisers; first stage is read by the second only
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            {a0_s1_q, a0_s2_q, b0_s1_q, b0_s2_q} <= 16'h0000;
            {c1_s1_q, c1_s2_q, d0_s1_q, d0_s2_q} <= 16'h0000;
            // ce stages reset to the pin's running level so release of reset is no false edge
            {ce_s1_q, ce_s2_q, stop_s1_q, stop_s2_q} <= 4'hc;
        end else begin
            {a0_s1_q, b0_s1_q, c1_s1_q, d0_s1_q} <= {PORT_A0_IN, PORT_B0_IN, PORT_C1_IN, PORT_D0_IN};
            {a0_s2_q, b0_s2_q, c1_s2_q, d0_s2_q} <= {a0_s1_q, b0_s1_q, c1_s1_q, d0_s1_q};
            {ce_s1_q, stop_s1_q} <= {CE_PIN_IN, CLK_STOP_IN};
            {ce_s2_q, stop_s2_q} <= {ce_s1_q, stop_s1_q};
        end
    end

    // ce edge and clock stop both send the ports back to input
    assign ce_rise = ce_s2_q & ~s_q.ce_prev;
    assign port_reset = ce_rise | stop_s2_q;

    // pin level seen by software: latch when driven, pin otherwise
    assign a0_pin = (s_q.dir_a0 & s_q.a0) | (~s_q.dir_a0 & a0_s2_q);
    assign b0_pin = (s_q.dir_b0 & s_q.b0) | (~s_q.dir_b0 & b0_s2_q);

    // next-state logic for the whole state register
    always_comb begin
        s_d = s_q;
        s_d.ce_prev = ce_s2_q;
        s_d.rdata = 4'h0;
        // writes: data memory latches by bank, register file words by address
        if (req.wr && !req.rf_sel) begin
            case ({req.bank, req.addr})
                {`GPP_BANK1, `GPP_ADR_A1}: s_d.a1 = req.wdata;
                {`GPP_BANK0, `GPP_ADR_A0}: s_d.a0 = req.wdata;
                {`GPP_BANK0, `GPP_ADR_B0}: s_d.b0 = req.wdata;
                {`GPP_BANK2, `GPP_ADR_B2}: s_d.b2 = req.wdata;
                {`GPP_BANK0, `GPP_ADR_C0}: s_d.c0 = req.wdata;
                {`GPP_BANK1, `GPP_ADR_C1}: s_d.c1 = req.wdata;
                {`GPP_BANK2, `GPP_ADR_C2}: s_d.c2 = req.wdata;
                default: ;
            endcase
        end else if (req.wr && req.rf_sel) begin
            case (req.addr)
                `GPP_RF_C1_DIR: s_d.dir_c1 = req.wdata[`GPP_C1_DIR_BIT];
                `GPP_RF_B0_DIR: s_d.dir_b0 = req.wdata;
                `GPP_RF_A0_DIR: s_d.dir_a0 = req.wdata;
                default: ;
            endcase
        end
        // reads answer next cycle; unmapped reads return zero
        if (req.rd && !req.rf_sel) begin
            case ({req.bank, req.addr})
                {`GPP_BANK1, `GPP_ADR_A1}: s_d.rdata = s_q.a1;
                {`GPP_BANK0, `GPP_ADR_A0}: s_d.rdata = a0_pin;
                {`GPP_BANK0, `GPP_ADR_B0}: s_d.rdata = b0_pin;
                {`GPP_BANK2, `GPP_ADR_B2}: s_d.rdata = s_q.b2;
                {`GPP_BANK0, `GPP_ADR_C0}: s_d.rdata = s_q.c0;
                {`GPP_BANK1, `GPP_ADR_C1}: s_d.rdata = s_q.dir_c1 ? s_q.c1 : c1_s2_q;
                {`GPP_BANK2, `GPP_ADR_C2}: s_d.rdata = s_q.c2;
                {`GPP_BANK0, `GPP_ADR_D0}: s_d.rdata = d0_s2_q;
                default: s_d.rdata = 4'h0;
            endcase
        end else if (req.rd) begin
            case (req.addr)
                `GPP_RF_C1_DIR: s_d.rdata = {3'h0, s_q.dir_c1};
                `GPP_RF_B0_DIR: s_d.rdata = s_q.dir_b0;
                `GPP_RF_A0_DIR: s_d.rdata = s_q.dir_a0;
                default: s_d.rdata = 4'h0;
            endcase
        end
        // reset events override any same-cycle direction write
        if (port_reset) begin
            s_d.dir_a0 = `GPP_DIR_IN;
            s_d.dir_b0 = `GPP_DIR_IN;
            s_d.dir_c1 = 1'b0;
        end
        // pin drive, from the next-state so outputs track the flops
        s_d.a1_o = 4'h0;
        s_d.a1_oe = ~s_d.a1;
        s_d.b2_oe = ~s_d.b2;
        s_d.c2_oe = ~s_d.c2;
        s_d.c0_o = s_d.c0;
        s_d.c1_o = s_d.c1;
        s_d.c1_oe = {4{s_d.dir_c1}};
        s_d.b0_o = s_d.b0;
        s_d.b0_oe = s_d.dir_b0;
        s_d.a0_o = s_d.a0;
        s_d.a0_oe = s_d.dir_a0;
        // serial sharing on port a0: three-wire on bits 3/2, two-wire on 1/0
        if (sio.sio_en && !sio.twowire_en) begin
            s_d.a0_o[`GPP_SO_BIT] = sio.so;
            s_d.a0_oe[`GPP_SO_BIT] = 1'b1;
            s_d.a0_o[`GPP_SCK_BIT] = sio.sck_out;
            s_d.a0_oe[`GPP_SCK_BIT] = sio.sck_oe;
        end
        if (sio.sio_en && sio.twowire_en) begin
            // open-drain lines only ever pull low
            s_d.a0_o[`GPP_SCL_BIT] = 1'b0;
            s_d.a0_oe[`GPP_SCL_BIT] = sio.scl_low | (s_d.dir_a0[`GPP_SCL_BIT] & ~s_d.a0[`GPP_SCL_BIT]);
            s_d.a0_o[`GPP_SDA_BIT] = 1'b0;
            s_d.a0_oe[`GPP_SDA_BIT] = sio.sda_low | (s_d.dir_a0[`GPP_SDA_BIT] & ~s_d.a0[`GPP_SDA_BIT]);
        end
        // alternate inputs taken from synchronised pins
        s_d.hs_in = b0_s2_q[`GPP_HSYNC_BIT];
        s_d.si_in = b0_s2_q[`GPP_SIO_DATA_IN_BIT];
        s_d.sck_in = a0_s2_q[`GPP_SCK_BIT];
        s_d.scl_in = a0_s2_q[`GPP_SCL_BIT];
        s_d.sda_in = a0_s2_q[`GPP_SDA_BIT];
    end

    // state register; reset leaves every bidirectional port as input
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            s_q <= '0;
            s_q.a1 <= `GPP_OD_RST; // open-drain latches released
            s_q.b2 <= `GPP_OD_RST;
            s_q.c2 <= `GPP_OD_RST;
            s_q.dir_a0 <= `GPP_DIR_IN;
            s_q.dir_b0 <= `GPP_DIR_IN;
            s_q.ce_prev <= 1'b1; // matches ce stage reset level
        end else begin
            s_q <= s_d;
        end
    end

    // ce reset pulse registered for the processor core
    logic ce_rst_q;
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ce_rst_q <= 1'b0;
        end else begin
            ce_rst_q <= ce_rise;
        end
    end

    // outputs straight from flops
    assign REG_RDATA_OUT = s_q.rdata;
    assign CE_RESET_OUT = ce_rst_q;
    assign PORT_A1_OUT = s_q.a1_o;
    assign PORT_A1_OE_OUT = s_q.a1_oe;
    assign PORT_A0_OUT = s_q.a0_o;
    assign PORT_A0_OE_OUT = s_q.a0_oe;
    assign PORT_B0_OUT = s_q.b0_o;
    assign PORT_B0_OE_OUT = s_q.b0_oe;
    assign PORT_B2_OE_OUT = s_q.b2_oe;
    assign PORT_C0_OUT = s_q.c0_o;
    assign PORT_C1_OUT = s_q.c1_o;
    assign PORT_C1_OE_OUT = s_q.c1_oe;
    assign PORT_C2_OE_OUT = s_q.c2_oe;
    assign HSYNC_CNT_OUT = s_q.hs_in;
    assign SIO_SI_OUT = s_q.si_in;
    assign SIO_SCK_OUT = s_q.sck_in;
    assign SIO_SCL_OUT = s_q.scl_in;
    assign SIO_SDA_OUT = s_q.sda_in;
endmodule : gpp_port_set

// *** gpp_defs.svh ***
// constants for the general-purpose port set: addresses, banks, field positions
// assumes the including file is a design or package compiled after this header
// Summary of operation
// - open-drain output port a1 at bank 1 70h
// - port b0 per-bit direction via word 36h
// - b0 bit3 hsync counter, bit0 serial in
// - b0 all inputs after any reset
// - port a0 per-bit direction via word 37h
// - a0 pins shared with serial interface
// - open-drain port b2 at bank 2 71h
// - open-drain port c2 at bank 2 72h
// - push-pull port c0 at bank 0 72h
// - c1 nibble direction from 27h bit 0
// - c1 forced input after any reset
// - input port d0 readable at bank 0 73h
// - chip-enable rising edge resets ports
`ifndef GPP_DEFS_SVH
`define GPP_DEFS_SVH
`define GPP_BANK_W 2
`define GPP_ADDR_W 7
`define GPP_BANK0 2'h0
`define GPP_BANK1 2'h1
`define GPP_BANK2 2'h2
`define GPP_ADR_A1 7'h70
`define GPP_ADR_A0 7'h70
`define GPP_ADR_B0 7'h71
`define GPP_ADR_B2 7'h71
`define GPP_ADR_C0 7'h72
`define GPP_ADR_C1 7'h72
`define GPP_ADR_C2 7'h72
`define GPP_ADR_D0 7'h73
`define GPP_RF_C1_DIR 7'h27
`define GPP_RF_B0_DIR 7'h36
`define GPP_RF_A0_DIR 7'h37
`define GPP_C1_DIR_BIT 0
`define GPP_SIO_DATA_IN_BIT 0
`define GPP_HSYNC_BIT 3
`define GPP_SO_BIT 3
`define GPP_SCK_BIT 2
`define GPP_SCL_BIT 1
`define GPP_SDA_BIT 0
`define GPP_LATCH_RST 4'h0
`define GPP_OD_RST 4'hf
`define GPP_DIR_IN 4'h0
`endif

// *** gpp_pkg.sv ***
// types for the general-purpose port set
// assumes gpp_defs.svh sits in the include path
`include "gpp_defs.svh"
package gpp_pkg;
    typedef logic [3:0] gpp_nib_t;

    // one register-bus request from the processor
    typedef struct packed {
        logic rf_sel;
        logic [`GPP_BANK_W-1:0] bank;
        logic [`GPP_ADDR_W-1:0] addr;
        gpp_nib_t wdata;
        logic wr;
        logic rd;
    } gpp_req_t;

    // serial interface hookup on port a0/b0 pins
    typedef struct packed {
        logic sio_en;
        logic twowire_en;
        logic so;
        logic sck_out;
        logic sck_oe;
        logic scl_low;
        logic sda_low;
    } gpp_sio_t;

    // all state of the port block except the synchronisers and the ce reset pulse
    typedef struct packed {
        gpp_nib_t a1;
        gpp_nib_t a0;
        gpp_nib_t b0;
        gpp_nib_t b2;
        gpp_nib_t c0;
        gpp_nib_t c1;
        gpp_nib_t c2;
        gpp_nib_t dir_a0;
        gpp_nib_t dir_b0;
        logic dir_c1;
        gpp_nib_t rdata;
        logic ce_prev;
        gpp_nib_t a1_o, a1_oe, a0_o, a0_oe, b0_o, b0_oe;
        gpp_nib_t b2_oe, c0_o, c1_o, c1_oe, c2_oe;
        logic hs_in, si_in, sck_in, scl_in, sda_in;
    } gpp_state_t;
endpackage : gpp_pkg

// *** gpp_port_set_checker.sv ***
// assertions on the port set's register port and pins
// assumes binding into gpp_port_set, one clock domain on MCLK_IN
`timescale 1ns/1ps
`include "gpp_defs.svh"
module gpp_port_set_checker (
    // clock and reset
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    // register port
    input wire logic REG_RF_SEL_IN,
    input wire logic [`GPP_BANK_W-1:0] REG_BANK_IN,
    input wire logic [`GPP_ADDR_W-1:0] REG_ADDR_IN,
    input wire logic [3:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [3:0] REG_RDATA_OUT,
    input wire logic CE_RESET_OUT,
    input wire logic CLK_STOP_IN,
    // pins
    input wire logic [3:0] PORT_B0_IN,
    input wire logic HSYNC_CNT_OUT,
    input wire logic [3:0] PORT_A1_OUT,
    input wire logic [3:0] PORT_B0_OE_OUT,
    input wire logic [3:0] PORT_B2_OE_OUT,
    input wire logic [3:0] PORT_C0_OUT,
    input wire logic [3:0] PORT_C1_OE_OUT
);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);
    logic dm_wr;
    logic [3:0] wd_q;
    // last data-memory write value, so latency may be one or two cycles
    assign dm_wr = REG_WR_IN && !REG_RF_SEL_IN;
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) wd_q <= 4'h0;
        else if (dm_wr) wd_q <= REG_WDATA_IN;
    end
    a_rdata_idle: assert property (!REG_RD_IN |=> REG_RDATA_OUT == 4'h0)
        else $error("read data not zero");
    a_a1_low: assert property (PORT_A1_OUT == 4'h0)
        else $error("a1 output not low");
    a_c1_group: assert property (PORT_C1_OE_OUT == 4'h0 || PORT_C1_OE_OUT == 4'hf)
        else $error("c1 direction split");
    a_ce_input: assert property (CE_RESET_OUT |-> ##[1:3] (PORT_B0_OE_OUT | PORT_C1_OE_OUT) == 4'h0)
        else $error("ce reset left outputs on");
    a_stop_input: assert property (CLK_STOP_IN [*6] |-> (PORT_B0_OE_OUT | PORT_C1_OE_OUT) == 4'h0)
        else $error("clock stop left outputs on");
    a_c0_write: assert property (dm_wr && REG_BANK_IN == `GPP_BANK0 && REG_ADDR_IN == `GPP_ADR_C0
        |-> ##[1:2] PORT_C0_OUT == wd_q) else $error("c0 not updated");
    a_b2_write: assert property (dm_wr && REG_BANK_IN == `GPP_BANK2 && REG_ADDR_IN == `GPP_ADR_B2
        |-> ##[1:2] PORT_B2_OE_OUT == ~wd_q) else $error("b2 not updated");
    a_hsync_follow: assert property ($stable(PORT_B0_IN[3]) [*5] |-> HSYNC_CNT_OUT == PORT_B0_IN[3])
        else $error("hsync input not passed");
endmodule : gpp_port_set_checker
bind gpp_port_set gpp_port_set_checker chk (.MCLK_IN, .RST_IN, .REG_RF_SEL_IN, .REG_BANK_IN, .REG_ADDR_IN,
    .REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT, .CE_RESET_OUT, .CLK_STOP_IN, .PORT_B0_IN,
    .HSYNC_CNT_OUT, .PORT_A1_OUT, .PORT_B0_OE_OUT, .PORT_B2_OE_OUT, .PORT_C0_OUT, .PORT_C1_OE_OUT);

// *** gpp_board.sv ***
// board model: pins the device leaves undriven follow outside levels
// assumes the bench supplies those levels on ext_in
`timescale 1ns/1ps
module gpp_board (
    // device drive
    input wire logic [3:0] a0_o_in,
    input wire logic [3:0] a0_oe_in,
    input wire logic [3:0] b0_o_in,
    input wire logic [3:0] b0_oe_in,
    input wire logic [3:0] c1_o_in,
    input wire logic [3:0] c1_oe_in,
    // outside levels: a0 [3:0], b0 [7:4], c1 [11:8]
    input wire logic [11:0] ext_in,
    // resolved pin levels
    output logic [3:0] a0_out,
    output logic [3:0] b0_out,
    output logic [3:0] c1_out
);
    // a bit follows the device only while its enable is high
    assign a0_out = (a0_o_in & a0_oe_in) | (ext_in[3:0] & ~a0_oe_in);
    assign b0_out = (b0_o_in & b0_oe_in) | (ext_in[7:4] & ~b0_oe_in);
    assign c1_out = (c1_o_in & c1_oe_in) | (ext_in[11:8] & ~c1_oe_in);
endmodule : gpp_board

// *** tb.sv ***
// self-checking bench for the port set: registers, pin drive, resets, serial sharing
// assumes gpp_board resolves the pins and the checker is bound in
`timescale 1ns/1ps
`include "gpp_defs.svh"
module tb;
    import gpp_pkg::*;
    logic clk, rst, ce, rf, wr, rd, stop, sen, two, so, sck, sckoe, scll, sdal, cer, si, scko, sclo, sdao, hs;
    logic [1:0] bank;
    logic [6:0] addr;
    logic [11:0] ext;
    gpp_nib_t wd, rdat, a0p, b0p, c1p, d0p, a1oe, a1o, a0o, a0oe, b0o, b0oe, b2oe, c0o, c1o, c1oe, c2oe, v, dr, lt;
    int errors = 0;
    int checks = 0;
    int n;
    gpp_port_set uut (.MCLK_IN(clk), .RST_IN(rst), .CE_PIN_IN(ce), .REG_RF_SEL_IN(rf), .REG_BANK_IN(bank),
        .REG_ADDR_IN(addr), .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdat),
        .CE_RESET_OUT(cer), .SIO_EN_IN(sen), .SIO_TWOWIRE_IN(two), .SIO_SO_IN(so), .SIO_SCK_IN(sck),
        .SIO_SCK_OE_IN(sckoe), .SIO_SCL_LOW_IN(scll), .SIO_SDA_LOW_IN(sdal), .SIO_SI_OUT(si),
        .SIO_SCK_OUT(scko), .SIO_SCL_OUT(sclo), .SIO_SDA_OUT(sdao), .HSYNC_CNT_OUT(hs), .CLK_STOP_IN(stop),
        .PORT_A0_IN(a0p), .PORT_B0_IN(b0p), .PORT_C1_IN(c1p), .PORT_D0_IN(d0p), .PORT_A1_OE_OUT(a1oe),
        .PORT_A1_OUT(a1o), .PORT_A0_OUT(a0o), .PORT_A0_OE_OUT(a0oe), .PORT_B0_OUT(b0o), .PORT_B0_OE_OUT(b0oe),
        .PORT_B2_OE_OUT(b2oe), .PORT_C0_OUT(c0o), .PORT_C1_OUT(c1o), .PORT_C1_OE_OUT(c1oe), .PORT_C2_OE_OUT(c2oe));
    gpp_board brd (.a0_o_in(a0o), .a0_oe_in(a0oe), .b0_o_in(b0o), .b0_oe_in(b0oe), .c1_o_in(c1o),
        .c1_oe_in(c1oe), .ext_in(ext), .a0_out(a0p), .b0_out(b0p), .c1_out(c1p));
    // expected read of a bidirectional port: latch where output, pin where input
    function automatic gpp_nib_t mix(gpp_nib_t d, gpp_nib_t l, gpp_nib_t p);
        return (l & d) | (p & ~d);
    endfunction : mix
    task automatic chk(input gpp_nib_t got, input gpp_nib_t exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wrr(input logic r, input logic [1:0] b, input logic [6:0] a, input gpp_nib_t d);
        @(posedge clk);
        {rf, bank, addr, wd, wr} <= {r, b, a, d, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
    endtask : wrr
    // read data stand only in the cycle after the strobe edge
    task automatic rdc(input logic r, input logic [1:0] b, input logic [6:0] a, input gpp_nib_t e);
        @(posedge clk);
        {rf, bank, addr, rd} <= {r, b, a, 1'b1};
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdat, e);
    endtask : rdc
    task automatic stop_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        {rst, ce, rf, wr, rd, stop, sen, two, so, sck, sckoe, scll, sdal} = 13'h1800;
        {bank, addr, wd, ext, d0p} = '0;
        void'($urandom(32'h985bbc13));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdc(1'b1, 2'h0, `GPP_RF_B0_DIR, 4'h0);
        rdc(1'b1, 2'h0, `GPP_RF_A0_DIR, 4'h0);
        rdc(1'b1, 2'h0, `GPP_RF_C1_DIR, 4'h0);
        chk(a1oe | b2oe | c2oe | b0oe | c1oe, 4'h0);
        $display("test reset state done");
        // random latches and directions, with an unmapped write after the mapped ones
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            v = 4'($urandom);
            dr = 4'($urandom);
            lt = 4'($urandom);
            ext <= 12'($urandom);
            d0p <= 4'($urandom);
            wrr(1'b0, `GPP_BANK1, `GPP_ADR_A1, v);
            wrr(1'b0, `GPP_BANK2, `GPP_ADR_B2, ~v);
            wrr(1'b0, `GPP_BANK2, `GPP_ADR_C2, lt);
            wrr(1'b0, `GPP_BANK0, `GPP_ADR_C0, v);
            wrr(1'b1, 2'h0, `GPP_RF_B0_DIR, dr);
            wrr(1'b0, `GPP_BANK0, `GPP_ADR_B0, lt);
            wrr(1'b1, 2'h0, `GPP_RF_A0_DIR, ~dr);
            wrr(1'b0, `GPP_BANK0, `GPP_ADR_A0, v);
            wrr(1'b1, 2'h3, `GPP_RF_C1_DIR, {3'h7, dr[0]});
            wrr(1'b0, `GPP_BANK1, `GPP_ADR_C1, lt);
            wrr(1'b0, `GPP_BANK1, 7'h7f, v);
            repeat (2) @(posedge clk);
            #1;
            chk(a1oe, ~v);
            chk(b2oe, v);
            chk(c2oe, ~lt);
            chk(c0o, v);
            chk(b0oe, dr);
            chk(b0o & dr, lt & dr);
            chk(c1oe, {4{dr[0]}});
            chk(c1o, lt);
            chk(a1o, 4'h0);
            rdc(1'b0, `GPP_BANK0, `GPP_ADR_B0, mix(dr, lt, ext[7:4]));
            rdc(1'b0, `GPP_BANK0, `GPP_ADR_A0, mix(~dr, v, ext[3:0]));
            rdc(1'b1, 2'h0, `GPP_RF_C1_DIR, {3'h0, dr[0]});
            if (!dr[0]) rdc(1'b0, `GPP_BANK1, `GPP_ADR_C1, ext[11:8]);
            else rdc(1'b0, `GPP_BANK1, `GPP_ADR_C1, lt);
            rdc(1'b0, `GPP_BANK0, `GPP_ADR_D0, d0p);
            rdc(1'b0, `GPP_BANK1, 7'h7f, 4'h0);
        end
        $display("test latches and directions done");
        // chip-enable rise clears directions, latches survive
        wrr(1'b1, 2'h0, `GPP_RF_B0_DIR, 4'hf);
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        n = 0;
        while (cer !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 20) begin
            errors++;
            stop_test();
        end
        repeat (4) @(posedge clk);
        #1;
        chk(b0oe | c1oe, 4'h0);
        chk(c0o, v);
        rdc(1'b1, 2'h0, `GPP_RF_B0_DIR, 4'h0);
        $display("test chip-enable reset done");
        // clock stop holds directions at input
        wrr(1'b1, 2'h0, `GPP_RF_B0_DIR, 4'hf);
        wrr(1'b1, 2'h0, `GPP_RF_C1_DIR, 4'h1);
        stop <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk(b0oe | c1oe, 4'h0);
        @(posedge clk);
        stop <= 1'b0;
        $display("test clock stop done");
        // serial sharing: three-wire drive, then two-wire pull-low
        wrr(1'b1, 2'h0, `GPP_RF_A0_DIR, 4'h0);
        {sen, so, sck, sckoe} <= 4'hf;
        ext <= 12'h0a5;
        repeat (6) @(posedge clk);
        #1;
        chk({a0o[3:2], a0oe[3:2]}, 4'hf);
        chk({hs, si, sdao, sclo}, 4'b1010);
        chk({3'h0, scko}, 4'h1);
        @(posedge clk);
        {two, sdal} <= 2'h3;
        repeat (6) @(posedge clk);
        #1;
        chk({1'b0, sdao, a0oe[0], a0o[0]}, 4'h2);
        $display("test serial sharing done");
        stop_test();
    end
endmodule : tb
